// File: rtl/gcs_pkg.sv
// gcs_pkg: constants for the graphics function command/status configuration registers.
// assumes a host bridge that issues dword configuration reads/writes with byte enables.
// Overview of operation
// - command bit 10 masks the legacy interrupt and upstream assert messages; resets 0
// - interrupt output asserts only when mask is 0 and pending status is 1
// - hardware sets pending status on interrupt event; software writes 1 to clear
// - setting the mask never changes pending status; status tracks internal state
// - command bit 2 gates master accesses; resets 0; no master access while 0
// - command bit 1 gates memory-space response; resets 0
// - command bit 0 gates io-space response; resets 0
// - command bits 15:11 reserved; bits 9:3 read 0 and ignore writes
// - detected parity errors are ignored without reporting
// - special cycles are ignored; write-and-invalidate is never issued
// - status bits 15:11 and 8 always read 0
// - status select timing field bits 10:9 always read 00
// - status bit 7 reads 1: back-to-back capability
// - status bits 6, 5 and 2:0 always read 0
// - status bit 4 reads 1: capability list present
package gcs_pkg;
  localparam logic [7:0] CFG_DWORD_OFS = 8'h04;
  localparam logic [7:0] GFX_COMMAND_OFS = 8'h04;
  localparam logic [7:0] GFX_STATUS_OFS = 8'h06;
  localparam logic [15:0] GFX_COMMAND_RST = 16'h0000;
  localparam logic [15:0] GFX_STATUS_RST = 16'h0090;
  localparam int CMD_IO_SPACE_BIT = 0;
  localparam int CMD_MEM_SPACE_BIT = 1;
  localparam int CMD_MASTER_BIT = 2;
  localparam int CMD_INT_MASK_BIT = 10;
  localparam int STS_INT_PENDING_BIT = 3;
  localparam int STS_WORD_LSB = 16;
  localparam int STS_PENDING_WBIT = STS_WORD_LSB + STS_INT_PENDING_BIT;
  localparam int STS_PENDING_LANE = STS_PENDING_WBIT / 8;
  localparam logic [15:0] CMD_WRITABLE = 16'h0407;
  localparam logic [15:0] STS_FIXED_ONES = 16'h0090;
endpackage : gcs_pkg

// File: rtl/gcs_command_status.sv
// gcs_command_status: command and status registers plus the gates they drive.
// assumes one-cycle config strobes on the dword at offset 04h; byte enables select lanes.
`timescale 1ns/100ps
`default_nettype none
module gcs_command_status (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // configuration access
  input wire logic cfgRd,
  input wire logic cfgWr,
  input wire logic [7:0] cfgAddr,
  input wire logic [3:0] cfgByteEn,
  input wire logic [31:0] cfgWrData,
  output logic [31:0] cfgRdData,
  output logic cfgRdValid,
  // function side
  input wire logic intEvent,
  input wire logic masterReq,
  input wire logic memAccess,
  input wire logic ioAccess,
  input wire logic parityErr,
  input wire logic specialCycle,
  output logic intxActive_n,
  output logic intAssertMsg,
  output logic masterGrant,
  output logic memClaim,
  output logic ioClaim,
  output logic memorySpaceGate,
  output logic ioSpaceGate,
  output logic masterAccessGate
);
  logic [15:0] command_r;
  logic pending_r;
  logic pendingSeen_r;
  logic hitDword;
  logic writeHit;
  logic pendingClear;
  logic intLive;
  logic [15:0] cmdMask;
  logic [15:0] stsLiveMask;
  logic [15:0] statusView;

  // byte enables 1:0 cover the command half of the dword
  function automatic logic [15:0] f_lane_mask(input logic [1:0] be);
    return {{8{be[1]}}, {8{be[0]}}};
  endfunction : f_lane_mask

  // the pin and the upstream message share one qualified condition
  function automatic logic f_int_live(input logic pending, input logic [15:0] cmd);
    return pending & ~cmd[gcs_pkg::CMD_INT_MASK_BIT];
  endfunction : f_int_live

  assign hitDword = (cfgAddr[7:2] == gcs_pkg::CFG_DWORD_OFS[7:2]);
  assign writeHit = cfgWr & hitDword;
  // the clear bit sits in byte 2, so a command-only write never drops a pending interrupt
  assign pendingClear = writeHit & cfgByteEn[gcs_pkg::STS_PENDING_LANE]
      & cfgWrData[gcs_pkg::STS_PENDING_WBIT];
  assign intLive = f_int_live(pending_r, command_r);
  // lanes 0/1 hold command, lanes 2/3 hold status
  assign cmdMask = f_lane_mask(cfgByteEn[1:0]) & gcs_pkg::CMD_WRITABLE;
  assign stsLiveMask = 16'h0001 << gcs_pkg::STS_INT_PENDING_BIT;
  // fixed ones and the single live bit; everything else is hardwired zero
  assign statusView = gcs_pkg::STS_FIXED_ONES
      | (stsLiveMask & {16{pending_r}});

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      command_r <= gcs_pkg::GFX_COMMAND_RST;
    end else if (cfgWr && hitDword) begin
      command_r <= (command_r & ~cmdMask) | (cfgWrData[15:0] & cmdMask);
    end
  end

  // set wins over a simultaneous write-one clear so no event is lost; mask never touches it
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pending_r <= 1'b0;
    end else if (intEvent) begin
      pending_r <= 1'b1;
    end else if (pendingClear) begin
      pending_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cfgRdData <= 32'h0000_0000;
      cfgRdValid <= 1'b0;
    end else begin
      cfgRdValid <= cfgRd;
      // unmapped offsets read zero
      cfgRdData <= (cfgRd && hitDword) ? {statusView, command_r} : 32'h0000_0000;
    end
  end

  // parity errors and special cycles are inputs only; nothing here reacts to them
  logic unusedIn;
  assign unusedIn = parityErr | specialCycle;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      intxActive_n <= 1'b1;
      intAssertMsg <= 1'b0;
      pendingSeen_r <= 1'b0;
    end else begin
      intxActive_n <= ~intLive;
      pendingSeen_r <= intLive;
      // one message per rising edge of the unmasked interrupt
      intAssertMsg <= intLive & ~pendingSeen_r;
    end
  end

  // grants and claims lag the request by one cycle so every output leaves a flop
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      masterGrant <= 1'b0;
      masterAccessGate <= 1'b0;
    end else begin
      masterGrant <= masterReq & command_r[gcs_pkg::CMD_MASTER_BIT];
      masterAccessGate <= command_r[gcs_pkg::CMD_MASTER_BIT];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      memClaim <= 1'b0;
      memorySpaceGate <= 1'b0;
    end else begin
      memClaim <= memAccess & command_r[gcs_pkg::CMD_MEM_SPACE_BIT];
      memorySpaceGate <= command_r[gcs_pkg::CMD_MEM_SPACE_BIT];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ioClaim <= 1'b0;
      ioSpaceGate <= 1'b0;
    end else begin
      ioClaim <= ioAccess & command_r[gcs_pkg::CMD_IO_SPACE_BIT];
      ioSpaceGate <= command_r[gcs_pkg::CMD_IO_SPACE_BIT];
    end
  end

  property p_int_gate;
    @(posedge mclk) disable iff (rst)
    !intxActive_n |-> $past(pending_r) && !$past(command_r[gcs_pkg::CMD_INT_MASK_BIT]);
  endproperty
  a_int_gate: assert property (p_int_gate) else $error("interrupt asserted while masked or idle");

  property p_mask_msg;
    @(posedge mclk) disable iff (rst)
    intAssertMsg |-> $past(!command_r[gcs_pkg::CMD_INT_MASK_BIT]);
  endproperty
  a_mask_msg: assert property (p_mask_msg) else $error("assert message sent while masked");

  property p_set;
    @(posedge mclk) disable iff (rst)
    intEvent |=> pending_r;
  endproperty
  a_set: assert property (p_set) else $error("pending not set by event");

  property p_mask_keeps;
    @(posedge mclk) disable iff (rst)
    (!intEvent && !pendingClear) |=> pending_r == $past(pending_r);
  endproperty
  a_mask_keeps: assert property (p_mask_keeps) else $error("pending changed without cause");

  property p_master;
    @(posedge mclk) disable iff (rst)
    masterGrant |-> $past(command_r[gcs_pkg::CMD_MASTER_BIT]);
  endproperty
  a_master: assert property (p_master) else $error("master access while gated off");

  property p_mem;
    @(posedge mclk) disable iff (rst)
    memClaim |-> $past(memAccess) && $past(command_r[gcs_pkg::CMD_MEM_SPACE_BIT]);
  endproperty
  a_mem: assert property (p_mem) else $error("memory claim while disabled");

  property p_io;
    @(posedge mclk) disable iff (rst)
    ioClaim |-> $past(ioAccess) && $past(command_r[gcs_pkg::CMD_IO_SPACE_BIT]);
  endproperty
  a_io: assert property (p_io) else $error("io claim while disabled");

  property p_cmd_ro;
    @(posedge mclk) disable iff (rst)
    (command_r & ~gcs_pkg::CMD_WRITABLE) == 16'h0000;
  endproperty
  a_cmd_ro: assert property (p_cmd_ro) else $error("read-only command bit set");

  property p_sts_fixed;
    @(posedge mclk) disable iff (rst)
    cfgRdValid && $past(hitDword) |-> (cfgRdData[31:16] & ~stsLiveMask) == gcs_pkg::STS_FIXED_ONES;
  endproperty
  a_sts_fixed: assert property (p_sts_fixed) else $error("status fixed bits wrong");

  property p_clear;
    @(posedge mclk) disable iff (rst)
    pendingClear && !intEvent |=> !pending_r;
  endproperty
  a_clear: assert property (p_clear) else $error("write-one did not clear pending");

  property p_set_wins;
    @(posedge mclk) disable iff (rst)
    intEvent && pendingClear |=> pending_r;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("clear beat a same-cycle event");

  property p_pending_view;
    @(posedge mclk) disable iff (rst)
    cfgRdValid && $past(hitDword) |-> cfgRdData[gcs_pkg::STS_PENDING_WBIT] == $past(pending_r);
  endproperty
  a_pending_view: assert property (p_pending_view) else $error("status read hides pending state");

  property p_intx_follow;
    @(posedge mclk) disable iff (rst)
    intLive |=> !intxActive_n;
  endproperty
  a_intx_follow: assert property (p_intx_follow) else $error("unmasked pending did not assert pin");

  property p_intx_masked;
    @(posedge mclk) disable iff (rst)
    command_r[gcs_pkg::CMD_INT_MASK_BIT] |=> intxActive_n;
  endproperty
  a_intx_masked: assert property (p_intx_masked) else $error("pin asserted while masked");

  property p_msg_rise;
    @(posedge mclk) disable iff (rst)
    intLive && !pendingSeen_r |=> intAssertMsg;
  endproperty
  a_msg_rise: assert property (p_msg_rise) else $error("no message on new interrupt");

  property p_msg_pulse;
    @(posedge mclk) disable iff (rst)
    intAssertMsg |=> !intAssertMsg;
  endproperty
  a_msg_pulse: assert property (p_msg_pulse) else $error("assert message longer than one cycle");

  property p_cmd_hold;
    @(posedge mclk) disable iff (rst)
    !writeHit |=> $stable(command_r);
  endproperty
  a_cmd_hold: assert property (p_cmd_hold) else $error("command changed without a write");

  property p_cmd_lane;
    @(posedge mclk) disable iff (rst)
    writeHit && !cfgByteEn[0] |=> command_r[7:0] == $past(command_r[7:0]);
  endproperty
  a_cmd_lane: assert property (p_cmd_lane) else $error("disabled byte lane written");

  property p_master_gate;
    @(posedge mclk) disable iff (rst)
    masterAccessGate == $past(command_r[gcs_pkg::CMD_MASTER_BIT]);
  endproperty
  a_master_gate: assert property (p_master_gate) else $error("master gate output stale");

  property p_mem_gate;
    @(posedge mclk) disable iff (rst)
    memorySpaceGate == $past(command_r[gcs_pkg::CMD_MEM_SPACE_BIT]);
  endproperty
  a_mem_gate: assert property (p_mem_gate) else $error("memory gate output stale");

  property p_io_gate;
    @(posedge mclk) disable iff (rst)
    ioSpaceGate == $past(command_r[gcs_pkg::CMD_IO_SPACE_BIT]);
  endproperty
  a_io_gate: assert property (p_io_gate) else $error("io gate output stale");

  property p_master_off;
    @(posedge mclk) disable iff (rst)
    !command_r[gcs_pkg::CMD_MASTER_BIT] |=> !masterGrant;
  endproperty
  a_master_off: assert property (p_master_off) else $error("grant while mastering disabled");

  property p_mem_off;
    @(posedge mclk) disable iff (rst)
    !command_r[gcs_pkg::CMD_MEM_SPACE_BIT] |=> !memClaim;
  endproperty
  a_mem_off: assert property (p_mem_off) else $error("memory claim while space disabled");

  property p_io_off;
    @(posedge mclk) disable iff (rst)
    !command_r[gcs_pkg::CMD_IO_SPACE_BIT] |=> !ioClaim;
  endproperty
  a_io_off: assert property (p_io_off) else $error("io claim while space disabled");

  property p_master_on;
    @(posedge mclk) disable iff (rst)
    masterReq && command_r[gcs_pkg::CMD_MASTER_BIT] |=> masterGrant;
  endproperty
  a_master_on: assert property (p_master_on) else $error("enabled master request not granted");

  property p_mem_on;
    @(posedge mclk) disable iff (rst)
    memAccess && command_r[gcs_pkg::CMD_MEM_SPACE_BIT] |=> memClaim;
  endproperty
  a_mem_on: assert property (p_mem_on) else $error("enabled memory access not claimed");

  property p_io_on;
    @(posedge mclk) disable iff (rst)
    ioAccess && command_r[gcs_pkg::CMD_IO_SPACE_BIT] |=> ioClaim;
  endproperty
  a_io_on: assert property (p_io_on) else $error("enabled io access not claimed");

  c_int: cover property (@(posedge mclk) disable iff (rst) intEvent ##1 !intxActive_n);
  c_masked: cover property (@(posedge mclk) disable iff (rst)
    pending_r && command_r[gcs_pkg::CMD_INT_MASK_BIT] ##1 intxActive_n);
  c_clear: cover property (@(posedge mclk) disable iff (rst) pending_r ##1 !pending_r);
  c_set_wins: cover property (@(posedge mclk) disable iff (rst) intEvent && pendingClear);
  c_msg: cover property (@(posedge mclk) disable iff (rst) intAssertMsg);
endmodule : gcs_command_status
`default_nettype wire

// File: test/gcs_host_model.sv
// gcs_host_model: host bridge issuing one-cycle configuration reads and writes.
// assumes read data is registered and answers exactly one cycle after the read strobe.
`timescale 1ns/100ps
`default_nettype none
module gcs_host_model (
  // clock
  input wire logic mclk,
  // configuration access
  output var logic cfgRd,
  output var logic cfgWr,
  output var logic [7:0] cfgAddr,
  output var logic [3:0] cfgByteEn,
  output var logic [31:0] cfgWrData,
  input wire logic [31:0] cfgRdData,
  input wire logic cfgRdValid
);
  initial begin
    {cfgRd, cfgWr, cfgAddr, cfgByteEn, cfgWrData} = '0;
  end
  task automatic access(input logic wr, input logic [7:0] a, input logic [3:0] be, input logic [31:0] d,
                        output logic [31:0] q, output logic v);
    @(posedge mclk);
    #1;
    cfgWr = wr;
    cfgRd = ~wr;
    cfgAddr = a;
    cfgByteEn = be;
    cfgWrData = d;
    @(posedge mclk);
    #1;
    q = cfgRdData;
    v = cfgRdValid;
    cfgWr = 1'b0;
    cfgRd = 1'b0;
    // released address and write-data lines show the inverse so stale values cannot pass
    cfgAddr = ~a;
    cfgWrData = ~d;
  endtask : access
endmodule : gcs_host_model
`default_nettype wire

// File: test/gfx_pci_command_status_tb.sv
// gfx_pci_command_status_tb: self-checking bench for the command/status registers.
// assumes gcs_host_model drives the configuration strobes.
`timescale 1ns/100ps
`default_nettype none
module gfx_pci_command_status_tb;
  logic mclk, rst, cfgRd, cfgWr, cfgRdValid, intEvent, masterReq, memAccess, ioAccess, parityErr, specialCycle;
  logic intxActive_n, intAssertMsg, masterGrant, memClaim, ioClaim, memorySpaceGate, ioSpaceGate, masterAccessGate;
  logic [7:0] cfgAddr;
  logic [3:0] cfgByteEn;
  logic [31:0] cfgWrData, cfgRdData, q;
  logic v;
  int n_fail = 0;
  int num_checks = 0;
  gcs_command_status DUT (.mclk, .rst, .cfgRd, .cfgWr, .cfgAddr, .cfgByteEn, .cfgWrData, .cfgRdData,
    .cfgRdValid, .intEvent, .masterReq, .memAccess, .ioAccess, .parityErr, .specialCycle, .intxActive_n,
    .intAssertMsg, .masterGrant, .memClaim, .ioClaim, .memorySpaceGate, .ioSpaceGate, .masterAccessGate);
  gcs_host_model host (.mclk, .cfgRd, .cfgWr, .cfgAddr, .cfgByteEn, .cfgWrData, .cfgRdData, .cfgRdValid);
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task rd(input logic [7:0] a, input logic [31:0] e);
    host.access(1'b0, a, 4'hf, 32'h0, q, v);
    chk({31'h0, v}, 32'h1);
    chk(q, e);
  endtask : rd
  task wr(input logic [3:0] be, input logic [31:0] d);
    host.access(1'b1, 8'h04, be, d, q, v);
  endtask : wr
  task t_reset;
    rd(8'h04, 32'h0090_0000);
    rd(8'h08, 32'h0);
    chk({28'h0, masterAccessGate, memorySpaceGate, ioSpaceGate, intxActive_n}, 32'h1);
    $display("test reset done");
  endtask : t_reset
  task t_gates;
    {masterReq, memAccess, ioAccess, parityErr, specialCycle} = 5'h1f;
    repeat (2) @(posedge mclk);
    #1;
    chk({29'h0, masterGrant, memClaim, ioClaim}, 32'h0);
    wr(4'hf, 32'hfff7_fbff);
    rd(8'h04, 32'h0090_0007);
    chk({26'h0, masterGrant, memClaim, ioClaim, masterAccessGate, memorySpaceGate, ioSpaceGate}, 32'h3f);
    wr(4'hf, 32'h0);
    @(posedge mclk);
    #1;
    chk({29'h0, masterGrant, memClaim, ioClaim}, 32'h0);
    $display("test gates done");
  endtask : t_gates
  task t_intr;
    @(posedge mclk);
    #1;
    intEvent = 1'b1;
    @(posedge mclk);
    #1;
    intEvent = 1'b0;
    @(posedge mclk);
    #1;
    chk({31'h0, intAssertMsg}, 32'h1);
    @(posedge mclk);
    #1;
    chk({30'h0, intAssertMsg, intxActive_n}, 32'h0);
    wr(4'h3, 32'h0008_0400);
    @(posedge mclk);
    #1;
    chk({31'h0, intxActive_n}, 32'h1);
    rd(8'h04, 32'h0098_0400);
    wr(4'hf, 32'h0000_0400);
    rd(8'h04, 32'h0098_0400);
    wr(4'h4, 32'h0008_0000);
    rd(8'h04, 32'h0090_0400);
    intEvent = 1'b1;
    @(posedge mclk);
    #1;
    intEvent = 1'b0;
    repeat (2) begin
      @(posedge mclk);
      #1;
      chk({30'h0, intAssertMsg, intxActive_n}, 32'h1);
    end
    rd(8'h04, 32'h0098_0400);
    wr(4'h3, 32'h0);
    @(posedge mclk);
    #1;
    chk({30'h0, intAssertMsg, intxActive_n}, 32'h2);
    intEvent = 1'b1;
    wr(4'h4, 32'h0008_0000);
    intEvent = 1'b0;
    rd(8'h04, 32'h0098_0000);
    wr(4'h4, 32'h0008_0000);
    rd(8'h04, 32'h0090_0000);
    $display("test interrupt done");
  endtask : t_intr
  task t_rerst;
    wr(4'h3, 32'h0000_0407);
    @(posedge mclk);
    #1;
    rst = 1'b1;
    @(posedge mclk);
    #1;
    rst = 1'b0;
    t_reset();
    $display("test mid-run reset done");
  endtask : t_rerst
  task report_and_stop;
    $display("checks=%0d fails=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop
  initial begin
    rst = 1'b1;
    {intEvent, masterReq, memAccess, ioAccess, parityErr, specialCycle} = '0;
    repeat (4) @(posedge mclk);
    #1;
    rst = 1'b0;
    t_reset();
    t_gates();
    t_intr();
    t_rerst();
    report_and_stop();
  end
endmodule : gfx_pci_command_status_tb
`default_nettype wire
